// >>> rtl/dfi_defs.svh
`ifndef DFI_DEFS_SVH
`define DFI_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DFI_OFS_CMD      12'h000
`define DFI_OFS_FEAT     12'h004
`define DFI_OFS_STAT     12'h008
`define DFI_OFS_ERR      12'h00c
`define DFI_OFS_DATA     12'h010
`define DFI_OFS_NATIVE   12'h014
`define DFI_OFS_HLIMIT   12'h018
`define DFI_OFS_CTRL     12'h01c
`define DFI_OFS_PROG     12'h020
// ----------------------------------------
// opcodes and codes
// ----------------------------------------
`define DFI_OP_FORMAT    8'hf7
`define DFI_OP_IDENTIFY  8'hec
`define DFI_OP_SEC_PREP  8'hf3
`define DFI_FEAT_MERGE   8'h11
// ----------------------------------------
// status and error bits
// ----------------------------------------
`define DFI_ST_BSY       7
`define DFI_ST_RDY       6
`define DFI_ST_DSC       4
`define DFI_ST_DRQ       3
`define DFI_ST_ERR       0
`define DFI_ER_ABT       2
`define DFI_ST_RESET     8'h50
// ----------------------------------------
// identify words and native capacity reset
// ----------------------------------------
`define DFI_ID_W0_BASE   16'h045a
`define DFI_ID_INC_BIT   2
`define DFI_ID_WORDS     9'h100
`define DFI_NATIVE_RESET 32'h0000_ffff
`endif

// >>> rtl/dfi_pkg.sv
package dfi_pkg;
	typedef enum logic [2:0] {
		DFI_IDLE  = 3'b000,
		DFI_MERGE = 3'b001,
		DFI_INIT  = 3'b010,
		DFI_IDENT = 3'b011,
		DFI_DONE  = 3'b100
	} dfi_state_t;
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} dfi_wreq_t;
endpackage

// >>> rtl/dfi_top.sv
`include "dfi_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dfi_top (
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	input  wire logic [11:0] S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output var  logic        S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output var  logic        S_AXI_WREADY,
	output var  logic [1:0]  S_AXI_BRESP,
	output var  logic        S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [11:0] S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output var  logic        S_AXI_ARREADY,
	output var  logic [31:0] S_AXI_RDATA,
	output var  logic [1:0]  S_AXI_RRESP,
	output var  logic        S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	output var  logic        SECTOR_WR,
	output var  logic [31:0] SECTOR_ADDR,
	output var  logic        LISTS_COMMIT
);
	import dfi_pkg::*;

	// ----------------------------------------
	// write channel capture
	// ----------------------------------------
	logic        aw_full_q, w_full_q, bvalid_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	wire         wr_go   = aw_full_q && w_full_q && !bvalid_q;
	wire         aw_take = S_AXI_AWVALID && !aw_full_q;
	wire         w_take  = S_AXI_WVALID && !w_full_q;
	dfi_wreq_t   wreq;
	assign wreq = '{addr: awaddr_q, data: wdata_q, strb: wstrb_q};

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			awaddr_q  <= 12'h000;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_full_q <= 1'b1;
				awaddr_q  <= S_AXI_AWADDR;
			end else if (wr_go) begin
				aw_full_q <= 1'b0;
			end
			if (w_take) begin
				w_full_q <= 1'b1;
				wdata_q  <= S_AXI_WDATA;
				wstrb_q  <= S_AXI_WSTRB;
			end else if (wr_go) begin
				w_full_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	dfi_state_t  state_q;
	wire         idle      = state_q == DFI_IDLE;
	wire         lane0     = wreq.strb[0];
	wire         wr_cmd    = wr_go && wreq.addr == `DFI_OFS_CMD && lane0;
	wire         wr_feat   = wr_go && wreq.addr == `DFI_OFS_FEAT && lane0;
	wire         wr_native = wr_go && wreq.addr == `DFI_OFS_NATIVE;
	wire         wr_hlim   = wr_go && wreq.addr == `DFI_OFS_HLIMIT;
	wire         wr_ctrl   = wr_go && wreq.addr == `DFI_OFS_CTRL && lane0;
	wire         wr_known  = wreq.addr <= `DFI_OFS_PROG && wreq.addr[1:0] == 2'b00;
	// commands written while busy are dropped, as a busy device ignores the task file
	wire         cmd_ok    = wr_cmd && idle;
	wire [7:0]   opcode    = wreq.data[7:0];

	// ----------------------------------------
	// command state
	// ----------------------------------------
	logic [7:0]  feat_q, status_q, error_q, prev_op_q;
	logic [31:0] native_q, hlimit_q, addr_q;
	logic [8:0]  word_q;
	logic        incomplete_q, reassign_pend_q, drq_q;
	wire         fmt_abort = (feat_q != `DFI_FEAT_MERGE) || (prev_op_q != `DFI_OP_SEC_PREP);
	wire         rd_data   = S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `DFI_OFS_DATA;
	wire [15:0]  id_word0  = `DFI_ID_W0_BASE & ~(16'h0001 << `DFI_ID_INC_BIT)
	                         | ({15'h0000, incomplete_q} << `DFI_ID_INC_BIT);
	wire [15:0]  id_word   = (word_q == 9'h000) ? id_word0 : 16'h0000;
	wire         last_addr = addr_q == native_q;

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q         <= DFI_IDLE;
			feat_q          <= 8'h00;
			status_q        <= `DFI_ST_RESET;
			error_q         <= 8'h00;
			prev_op_q       <= 8'h00;
			native_q        <= `DFI_NATIVE_RESET;
			hlimit_q        <= `DFI_NATIVE_RESET;
			addr_q          <= 32'h0000_0000;
			word_q          <= 9'h000;
			incomplete_q    <= 1'b0;
			reassign_pend_q <= 1'b0;
			drq_q           <= 1'b0;
			SECTOR_WR       <= 1'b0;
			SECTOR_ADDR     <= 32'h0000_0000;
			LISTS_COMMIT    <= 1'b0;
		end else begin
			SECTOR_WR    <= 1'b0;
			LISTS_COMMIT <= 1'b0;
			if (wr_feat)
				feat_q <= wreq.data[7:0];
			if (wr_native)
				native_q <= wreq.data;
			if (wr_hlim)
				hlimit_q <= wreq.data;
			if (wr_ctrl) begin
				incomplete_q    <= wreq.data[0];
				reassign_pend_q <= wreq.data[1];
			end
			case (state_q)
				DFI_IDLE: begin
					if (cmd_ok) begin
						prev_op_q <= opcode;
						error_q   <= 8'h00;
						if (opcode == `DFI_OP_FORMAT) begin
							if (fmt_abort) begin
								error_q  <= 8'h01 << `DFI_ER_ABT;
								status_q <= 8'h41;
							end else begin
								status_q <= 8'h80;
								state_q  <= DFI_MERGE;
							end
						end else if (opcode == `DFI_OP_IDENTIFY) begin
							status_q <= 8'h58;
							drq_q    <= 1'b1;
							word_q   <= 9'h000;
							state_q  <= DFI_IDENT;
						end else begin
							status_q <= `DFI_ST_RESET;
						end
					end
				end
				DFI_MERGE: begin
					// reassign entries fold into defects; list is cleared here
					reassign_pend_q <= 1'b0;
					addr_q          <= 32'h0000_0000;
					state_q         <= DFI_INIT;
				end
				DFI_INIT: begin
					// host limit deliberately unused: protected area is wiped too
					SECTOR_WR   <= 1'b1;
					SECTOR_ADDR <= addr_q;
					addr_q      <= addr_q + 32'h0000_0001;
					if (last_addr)
						state_q <= DFI_DONE;
				end
				DFI_DONE: begin
					LISTS_COMMIT <= 1'b1;
					status_q     <= `DFI_ST_RESET;
					state_q      <= DFI_IDLE;
				end
				DFI_IDENT: begin
					if (rd_data) begin
						word_q <= word_q + 9'h001;
						if (word_q == `DFI_ID_WORDS - 9'h001) begin
							drq_q    <= 1'b0;
							status_q <= `DFI_ST_RESET;
							state_q  <= DFI_IDLE;
						end
					end
				end
				default: state_q <= DFI_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	wire         ar_take = S_AXI_ARVALID && !rvalid_q;
	logic [31:0] rd_mux;
	logic        rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		case (S_AXI_ARADDR)
			`DFI_OFS_CMD:    rd_mux = {24'h000000, prev_op_q};
			`DFI_OFS_FEAT:   rd_mux = {24'h000000, feat_q};
			`DFI_OFS_STAT:   rd_mux = {24'h000000, status_q};
			`DFI_OFS_ERR:    rd_mux = {24'h000000, error_q};
			`DFI_OFS_DATA:   rd_mux = {16'h0000, (state_q == DFI_IDENT) ? id_word : 16'h0000};
			`DFI_OFS_NATIVE: rd_mux = native_q;
			`DFI_OFS_HLIMIT: rd_mux = hlimit_q;
			`DFI_OFS_CTRL:   rd_mux = {30'h0000_0000, reassign_pend_q, incomplete_q};
			`DFI_OFS_PROG:   rd_mux = addr_q;
			default: begin
				rd_mux = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= 2'b00;
			bvalid_q <= 1'b0;
			S_AXI_BRESP <= 2'b00;
		end else begin
			if (ar_take) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_mux;
				rresp_q  <= rd_hit ? 2'b00 : 2'b10;
			end else if (S_AXI_RREADY)
				rvalid_q <= 1'b0;
			if (wr_go) begin
				bvalid_q    <= 1'b1;
				S_AXI_BRESP <= wr_known ? 2'b00 : 2'b10;
			end else if (S_AXI_BREADY)
				bvalid_q <= 1'b0;
		end
	end

	assign S_AXI_AWREADY = !aw_full_q;
	assign S_AXI_WREADY  = !w_full_q;
	assign S_AXI_BVALID  = bvalid_q;
	assign S_AXI_ARREADY = !rvalid_q;
	assign S_AXI_RVALID  = rvalid_q;
	assign S_AXI_RDATA   = rdata_q;
	assign S_AXI_RRESP   = rresp_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_fmt_bad;
		cmd_ok && opcode == `DFI_OP_FORMAT && fmt_abort;
	endsequence
	sequence s_fmt_good;
		cmd_ok && opcode == `DFI_OP_FORMAT && !fmt_abort;
	endsequence
	sequence s_word0_read;
		ar_take && S_AXI_ARADDR == `DFI_OFS_DATA && state_q == DFI_IDENT && word_q == 9'h000;
	endsequence
	sequence s_ident_last;
		rd_data && state_q == DFI_IDENT && word_q == 9'h0ff;
	endsequence
	// first sector pulse comes two edges after merge, one for the counter clear
	sequence s_first_sector;
		##1 SECTOR_WR && SECTOR_ADDR == 32'h0000_0000;
	endsequence

	a_format_start: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		s_fmt_good |=> state_q == DFI_MERGE)
		else $error("format did not start");
	a_bad_feature: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		s_fmt_bad |=> error_q[`DFI_ER_ABT] && status_q[`DFI_ST_ERR] && idle)
		else $error("bad format not aborted");
	a_abort_quiet: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		s_fmt_bad |=> !status_q[`DFI_ST_BSY] && !drq_q && !SECTOR_WR)
		else $error("aborted format still ran");
	a_need_prepare: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(state_q == DFI_MERGE) |-> $past(prev_op_q) == `DFI_OP_SEC_PREP)
		else $error("format ran without prepare");
	a_init_from_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(state_q == DFI_MERGE) |=> s_first_sector)
		else $error("init not from zero");
	a_sector_step: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(state_q == DFI_INIT) |=> SECTOR_WR && SECTOR_ADDR == $past(addr_q))
		else $error("sector sequence broken");
	a_last_native: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(state_q == DFI_DONE) |-> SECTOR_WR && SECTOR_ADDR == native_q)
		else $error("init did not end at native top");
	a_clear_reassign: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		$rose(LISTS_COMMIT) |-> !reassign_pend_q && $past(state_q) == DFI_DONE)
		else $error("commit with reassign pending");
	a_reassign_gone: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(state_q == DFI_MERGE) |=> !reassign_pend_q)
		else $error("reassign list not cleared");
	a_commit_pulse: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(state_q == DFI_DONE) |=> LISTS_COMMIT && idle)
		else $error("lists not committed");
	a_no_data_phase: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(state_q inside {DFI_MERGE, DFI_INIT, DFI_DONE}) |-> !drq_q && !status_q[`DFI_ST_DRQ])
		else $error("data request in format");
	a_identify_go: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		cmd_ok && opcode == `DFI_OP_IDENTIFY |=> drq_q && word_q == 9'h000)
		else $error("identify not started");
	a_drq_ident: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(state_q == DFI_IDENT) |-> drq_q && status_q[`DFI_ST_DRQ])
		else $error("data request missing in identify");
	a_word0_value: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		s_word0_read |=> (S_AXI_RDATA[15:0] & 16'hfffb) == 16'h045a && S_AXI_RDATA[2] == $past(incomplete_q))
		else $error("word 0 wrong");
	a_word_order: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		rd_data && state_q == DFI_IDENT && word_q != 9'h0ff |=> word_q == $past(word_q) + 9'h001)
		else $error("word order broken");
	a_ident_end: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		s_ident_last |=> idle && !drq_q && status_q == `DFI_ST_RESET)
		else $error("identify did not end after last word");
	a_busy_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(state_q inside {DFI_MERGE, DFI_INIT}) |-> status_q[`DFI_ST_BSY])
		else $error("busy dropped in format");
	a_format_end: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(state_q == DFI_DONE) |=> status_q == 8'h50)
		else $error("bad completion status");

	// ----------------------------------------
	// bus handshake checks
	// ----------------------------------------
	// answers must stand until taken, or a slow host loses them
	a_bvalid_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write answer dropped");
	a_rvalid_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
		else $error("read answer dropped");
	a_b_answer: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		wr_go |=> S_AXI_BVALID)
		else $error("write answer late");
	a_r_answer: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		ar_take |=> S_AXI_RVALID)
		else $error("read answer late");
endmodule
`default_nettype wire

// >>> tb/dfi_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host controller model, axi-lite master
// ----------------------------------------
module dfi_host (
	input  wire logic        clk,
	output var  logic [11:0] awaddr,
	output var  logic        awvalid,
	input  wire logic        awready,
	output var  logic [31:0] wdata,
	output var  logic [3:0]  wstrb,
	output var  logic        wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output var  logic        bready,
	output var  logic [11:0] araddr,
	output var  logic        arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output var  logic        rready
);
	logic [1:0] last_bresp;
	initial begin
		last_bresp = 2'b11;
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		wstrb = 4'hf;
	end
	// sampled at the falling edge: readies only move on rising edges
	// released lines turn inverted so a late capture cannot match
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ta, tw, hb;
		@(posedge clk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
		forever begin
			@(negedge clk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			hb = bvalid;
			if (hb) last_bresp = bresp;
			@(posedge clk);
			if (ta) {awvalid, awaddr} <= {1'b0, ~a};
			if (tw) {wvalid, wdata} <= {1'b0, ~d};
			if (hb) begin
				bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, hr;
		@(posedge clk);
		{araddr, arvalid, rready} <= {a, 2'b11};
		forever begin
			@(negedge clk);
			ta = arvalid & arready;
			hr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ta) {arvalid, araddr} <= {1'b0, ~a};
			if (hr) begin
				rready <= 1'b0;
				break;
			end
		end
	endtask
endmodule
`default_nettype wire

// >>> tb/dfi_top_tb_top.sv
`include "dfi_defs.svh"
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// format and identify bench
// ----------------------------------------
module dfi_top_tb_top;
	import dfi_pkg::*;
	logic             clk, rst_n;
	wire logic [11:0] awaddr, araddr;
	wire logic [31:0] wdata, rdata, sec_addr;
	wire logic [3:0]  wstrb;
	wire logic [1:0]  bresp, rresp;
	wire logic        awvalid, awready, wvalid, wready, bvalid, bready;
	wire logic        arvalid, arready, rvalid, rready, sec_wr, commit;
	int               error_cnt = 0, samples_checked = 0, nsec = 0, ncommit = 0;
	logic [31:0]      v;
	logic [1:0]       rs;
	dfi_host host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	dfi_top dut (.SYS_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SECTOR_WR(sec_wr),
		.SECTOR_ADDR(sec_addr), .LISTS_COMMIT(commit));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'b00);
		host.rd(a, v, rs);
		chk_reg(v, e);
		chk_reg({30'h0, rs}, {30'h0, er});
	endtask
	// registered pulses are judged mid-cycle, away from their launch edge
	always @(negedge clk) begin
		if (sec_wr) begin
			chk_reg(sec_addr, nsec);
			nsec++;
		end
		if (commit) ncommit++;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic t_abort;
		rdc(`DFI_OFS_STAT, 32'h50);
		host.wr(`DFI_OFS_FEAT, 32'h12);
		host.wr(`DFI_OFS_CMD, 32'hf3);
		host.wr(`DFI_OFS_CMD, 32'hf7);
		rdc(`DFI_OFS_STAT, 32'h41);
		rdc(`DFI_OFS_ERR, 32'h04);
		host.wr(`DFI_OFS_FEAT, 32'h11);
		host.wr(`DFI_OFS_CMD, 32'hf7);
		rdc(`DFI_OFS_STAT, 32'h41);
		rdc(`DFI_OFS_ERR, 32'h04);
		chk_reg(nsec, 32'h0);
		chk_reg({30'h0, host.last_bresp}, 32'h0);
		host.wr(12'h024, 32'h1);
		chk_reg({30'h0, host.last_bresp}, 32'h2);
		rdc(12'h024, 32'h0, 2'b10);
		$display("test abort done");
	endtask
	task automatic t_format;
		int n;
		rdc(`DFI_OFS_NATIVE, 32'hffff);
		host.wr(`DFI_OFS_NATIVE, 32'h10);
		host.wr(`DFI_OFS_HLIMIT, 32'h4);
		host.wr(`DFI_OFS_CTRL, 32'h2);
		host.wr(`DFI_OFS_FEAT, 32'h11);
		host.wr(`DFI_OFS_CMD, 32'hf3);
		host.wr(`DFI_OFS_CMD, 32'hf7);
		rdc(`DFI_OFS_STAT, 32'h80);
		n = 0;
		// poll bound sized for the shortened capacity
		do begin
			host.rd(`DFI_OFS_STAT, v, rs);
			chk_reg(v & 32'h08, 32'h0);
			n++;
		end while (v[`DFI_ST_BSY] === 1'b1 && n < 200);
		chk_reg(v, 32'h50);
		chk_reg(nsec, 32'h11);
		chk_reg(ncommit, 32'h1);
		rdc(`DFI_OFS_CTRL, 32'h0);
		$display("test format done");
	endtask
	task automatic t_ident(input logic inc);
		host.wr(`DFI_OFS_CTRL, {31'h0, inc});
		host.wr(`DFI_OFS_CMD, 32'hec);
		rdc(`DFI_OFS_STAT, 32'h58);
		rdc(`DFI_OFS_DATA, 32'h045a | {29'h0, inc, 2'b00});
		for (int i = 1; i < 256; i++) begin
			rdc(`DFI_OFS_DATA, 32'h0);
		end
		rdc(`DFI_OFS_STAT, 32'h50);
		$display("test identify done");
	endtask
	initial begin
		rst_n = 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_abort();
		t_format();
		t_ident(1'b1);
		t_ident(1'b0);
		summarize();
	end
	// the tests need about 1700 cycles
	initial begin
		#(20000 * 10);
		error_cnt++;
		summarize();
	end
endmodule
`default_nettype wire
